/* File: rtl/osdca_pkg.sv */
// constants and types for the osd character attribute block
package osdca_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL1  = 8'h00;
  localparam logic [7:0] ADR_CTRL2  = 8'h04;
  localparam logic [7:0] ADR_BORDER = 8'h08;
  localparam logic [7:0] ADR_CTRL3  = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // display control 1 bits
  localparam int C1_BISCAN     = 1;
  localparam int C1_BORDER_ALL = 2;
  localparam int C1_FLASH_ALL  = 3;
  localparam int C1_SOLID_EN   = 4;
  // display control 2 bits
  localparam int C2_SOLID_SEC  = 3;
  localparam int C2_IRQ_LAYER2 = 7;
  // control 3 bits
  localparam int C3_PREDIV2    = 0;
  localparam int C3_DOT_1P5    = 1;
  // status fields
  localparam int ST_PHASE_OFF  = 0;
  localparam int ST_VCOUNT     = 1;
  localparam int ST_NEST       = 8;
  localparam int ST_IRQ_COUNT  = 16;
  // flash timing in vertical periods
  localparam logic [5:0] FLASH_ON_VPER  = 6'd48;
  localparam logic [5:0] FLASH_OFF_VPER = 6'd16;
  // font geometry, lines counted from 0
  localparam logic [4:0] FONT_LINES  = 5'd26;
  localparam logic [4:0] LAST_LINE   = 5'd25;
  localparam logic [4:0] UL_LINE_A   = 5'd22;
  localparam logic [4:0] UL_LINE_B   = 5'd23;
  localparam logic [4:0] SLANT_R1    = 5'd5;
  localparam logic [4:0] SLANT_R2    = 5'd10;
  localparam logic [8:0] NO_SOLID_CODE = 9'h009;
  localparam logic [3:0] BORDER_PAL  = 4'h8;
  localparam logic [3:0] SOLID_BG_PAL = 4'h8;
  localparam logic [3:0] CLEAR_PAL   = 4'h0;

  typedef enum logic {osdca_ph_on, osdca_ph_off} osdca_phase_t;

  typedef struct packed {
    logic [7:0]   ctrl1;
    logic [7:0]   ctrl2;
    logic [7:0]   ctrl3;
    logic [15:0]  border_en;
    logic         ack;
    logic [31:0]  rdata;
    osdca_phase_t phase;
    logic [5:0]   vcount;
    logic [3:0]   nest;
    logic         irq;
    logic [7:0]   irq_count;
    logic [3:0]   color;
    logic         font_on;
    logic         blank_p;
    logic         blank_s;
    logic [10:0]  vstart;
    logic [3:0]   vrepeat;
  } osdca_state_t;
endpackage : osdca_pkg

/* File: rtl/osdca_top.sv */
// osd character attribute, border, solid space, interrupt and scan logic
// Summary of operation
// - caption underline drawn on font lines 23 and 24 in font color
// - each per-character attribute bit: 0 off, 1 on
// - flash only in caption mode and only for characters with flash bit
// - flash scope 0: only font and underline of flashing characters flash
// - scope 1: rgb and primary blank flash; solid-space cells flash rgb only
// - flash on 48 vertical periods, off 16, counted on vsync
// - caption italic slants the stored font to the right
// - italic flashing chars flash italic; spill into flashing cell flashes
// - secondary blank output never flashes
// - slant is 1 dot in 5 steps at ratio 1, half dot in 10 at ratio 2
// - slant moves font edge not background; neighbours also shown italic
// - 32nd char italic, solid space off: spill past the line is hidden
// - borders only in overlay mode; all-around or shadow; per-block enable
// - border pixels raise primary blank in color code 8
// - border one divided dot wide, 1.5 at ratio 2 with 1.5 dot size
// - next font beats border; border beats background; no vertical spill
// - interrupt at end of displayed block of selected layer
// - none for off blocks; nested blocks give one; off caption outside window
// - auto solid space covers non-009 cells and their neighbours
// - solid space enable and routing to primary or secondary blank
// - solid space on primary forces background palette 8
// - secondary blank covers display area and routed solid space
// - bi-scan doubles vertical start and dot height
//
// Chosen here: register access over Wishbone and the placing of the registers.
module osdca_top (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        vsync_pulse,
  input  wire logic        caption_mode,
  input  wire logic        overlay_mode,
  input  wire logic        in_char_area,
  input  wire logic        past_last_char,
  input  wire logic [4:0]  font_line,
  input  wire logic [3:0]  dot_col,
  input  wire logic        dot_half,
  input  wire logic [15:0] font_row,
  input  wire logic [15:0] font_row_up,
  input  wire logic [15:0] font_row_dn,
  input  wire logic [15:0] left_row,
  input  wire logic [15:0] right_row,
  input  wire logic [8:0]  char_code,
  input  wire logic [8:0]  left_code,
  input  wire logic [8:0]  right_code,
  input  wire logic        char_slant_bit,
  input  wire logic        left_slant_bit,
  input  wire logic        right_slant_bit,
  input  wire logic        char_blink_bit,
  input  wire logic        char_underline_bit,
  input  wire logic        char_second_blank_bit,
  input  wire logic [3:0]  font_pal,
  input  wire logic [3:0]  back_pal,
  input  wire logic [3:0]  block_index,
  input  wire logic        block_start,
  input  wire logic        block_end,
  input  wire logic        block_layer2,
  input  wire logic        block_shown,
  input  wire logic        block_window_off,
  input  wire logic [9:0]  vpos,
  input  wire logic [2:0]  dot_height,
  output logic [3:0]       pix_pal,
  output logic             pix_font,
  output logic             blank_out_primary,
  output logic             blank_out_secondary,
  output logic             osd_irq,
  output logic [10:0]      vstart_line,
  output logic [3:0]       line_repeat
);

  osdca_pkg::osdca_state_t st;
  osdca_pkg::osdca_state_t next_st;

  // column in a three-cell window: left cell 0..15, own 16..31, right 32..47
  function automatic logic row_bit(input logic [47:0] w, input logic signed [7:0] idx);
    if (idx < 8'sd0 || idx > 8'sd47) begin
      row_bit = 1'b0;
    end else begin
      row_bit = w[idx[5:0]];
    end
  endfunction : row_bit

  // slant in half dots, largest at the top line
  function automatic logic [4:0] slant(input logic [4:0] line, input logic r2);
    logic [9:0] prod;
    prod = {5'd0, osdca_pkg::LAST_LINE - line}
           * {5'd0, r2 ? osdca_pkg::SLANT_R2 : osdca_pkg::SLANT_R1};
    prod = prod / {5'd0, osdca_pkg::FONT_LINES};
    slant = r2 ? prod[4:0] : {prod[3:0], 1'b0};
  endfunction : slant

  logic [47:0]       row_w;
  logic [47:0]       up_w;
  logic [47:0]       dn_w;
  logic signed [7:0] col;
  logic signed [7:0] src;
  logic              prediv2;
  logic              solid_on;
  logic              solid_sec;
  logic              italic;
  logic              font_px;
  logic              ul_px;
  logic              fg;
  logic              blink;
  logic              blink_cell;
  logic              solid_cell;
  logic              nb_shadow;
  logic              nb_all;
  logic              wide;
  logic              border_px;
  logic              irq_sel;
  logic              irq_elig;
  logic              irq_fire;

  assign row_w    = {right_row, font_row, left_row};
  assign up_w     = {16'h0000, font_row_up, 16'h0000};
  assign dn_w     = {16'h0000, font_row_dn, 16'h0000};
  assign col      = 8'sd16 + $signed({4'd0, dot_col});
  assign prediv2  = st.ctrl3[osdca_pkg::C3_PREDIV2];
  assign solid_on = caption_mode & st.ctrl1[osdca_pkg::C1_SOLID_EN];
  assign solid_sec = st.ctrl2[osdca_pkg::C2_SOLID_SEC];

  // neighbours of an italic cell are drawn italic too, so edges line up
  assign italic = caption_mode
                  & (char_slant_bit | left_slant_bit | right_slant_bit);
  // source dot is taken further left; spill from the left cell lands here
  assign src = $signed({col[6:0], dot_half})
               - $signed({3'd0, slant(font_line, prediv2)});
  assign font_px = italic ? row_bit(row_w, src >>> 1)
                          : row_bit(row_w, col);
  assign ul_px = caption_mode & char_underline_bit
                 & (font_line == osdca_pkg::UL_LINE_A
                    | font_line == osdca_pkg::UL_LINE_B);
  // spill right of the last cell shows only over solid space
  assign fg = (font_px | ul_px)
              & (in_char_area | (past_last_char & solid_on));

  // flash uses the bit of the cell the dot lands in, so spill follows it
  assign blink = caption_mode & char_blink_bit
                 & (st.phase == osdca_pkg::osdca_ph_off);
  assign blink_cell = blink & st.ctrl1[osdca_pkg::C1_FLASH_ALL];

  assign solid_cell = solid_on & in_char_area
                      & (char_code != osdca_pkg::NO_SOLID_CODE
                         | left_code != osdca_pkg::NO_SOLID_CODE
                         | right_code != osdca_pkg::NO_SOLID_CODE);

  // border: up/down rows are zero-filled past the cell, which hides vertical spill
  assign wide = prediv2 & st.ctrl3[osdca_pkg::C3_DOT_1P5];
  assign nb_shadow = row_bit(row_w, col - 8'sd1)
                     | (wide & ~dot_half & row_bit(row_w, col - 8'sd2))
                     | (font_line != 5'd0 & (row_bit(up_w, col)
                        | row_bit(up_w, col - 8'sd1)));
  assign nb_all = nb_shadow | row_bit(row_w, col + 8'sd1)
                  | (wide & dot_half & row_bit(row_w, col + 8'sd2))
                  | (font_line != osdca_pkg::LAST_LINE & (row_bit(dn_w, col)
                     | row_bit(dn_w, col + 8'sd1) | row_bit(dn_w, col - 8'sd1)))
                  | (font_line != 5'd0 & row_bit(up_w, col + 8'sd1));
  assign border_px = overlay_mode & in_char_area & ~fg
                     & st.border_en[block_index]
                     & (st.ctrl1[osdca_pkg::C1_BORDER_ALL] ? nb_all : nb_shadow);

  assign irq_sel = block_layer2 == st.ctrl2[osdca_pkg::C2_IRQ_LAYER2];
  assign irq_elig = irq_sel & (block_shown | block_window_off);
  // a nested block only bumps the depth; the outermost end fires
  assign irq_fire = block_end & irq_elig & (st.nest <= 4'd1);

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    rd = 32'h0000_0000;
    hit = wb_cyc_i & wb_stb_i & ~st.ack;
    next_st = st;
    next_st.ack = hit;
    // bus: single-cycle answer, unmapped reads give zero, writes ignored
    if (hit & wb_we_i & wb_sel_i[0]) begin
      case (wb_adr_i)
        osdca_pkg::ADR_CTRL1:  next_st.ctrl1 = wb_dat_i[7:0];
        osdca_pkg::ADR_CTRL2:  next_st.ctrl2 = wb_dat_i[7:0];
        osdca_pkg::ADR_CTRL3:  next_st.ctrl3 = wb_dat_i[7:0];
        osdca_pkg::ADR_BORDER: next_st.border_en[7:0] = wb_dat_i[7:0];
        default: ;
      endcase
    end
    if (hit & wb_we_i & wb_sel_i[1] & wb_adr_i == osdca_pkg::ADR_BORDER) begin
      next_st.border_en[15:8] = wb_dat_i[15:8];
    end
    case (wb_adr_i)
      osdca_pkg::ADR_CTRL1:  rd[7:0] = st.ctrl1;
      osdca_pkg::ADR_CTRL2:  rd[7:0] = st.ctrl2;
      osdca_pkg::ADR_CTRL3:  rd[7:0] = st.ctrl3;
      osdca_pkg::ADR_BORDER: rd[15:0] = st.border_en;
      osdca_pkg::ADR_STATUS: begin
        rd[osdca_pkg::ST_PHASE_OFF] = (st.phase == osdca_pkg::osdca_ph_off);
        rd[osdca_pkg::ST_VCOUNT +: 6] = st.vcount;
        rd[osdca_pkg::ST_NEST +: 4] = st.nest;
        rd[osdca_pkg::ST_IRQ_COUNT +: 8] = st.irq_count;
      end
      default: rd = 32'h0000_0000;
    endcase
    next_st.rdata = hit ? rd : 32'h0000_0000;

    // flash phase: free-running, shared by every character
    if (vsync_pulse) begin
      case (st.phase)
        osdca_pkg::osdca_ph_on: begin
          if (st.vcount == osdca_pkg::FLASH_ON_VPER - 6'd1) begin
            next_st.phase = osdca_pkg::osdca_ph_off;
            next_st.vcount = 6'd0;
          end else begin
            next_st.vcount = st.vcount + 6'd1;
          end
        end
        osdca_pkg::osdca_ph_off: begin
          if (st.vcount == osdca_pkg::FLASH_OFF_VPER - 6'd1) begin
            next_st.phase = osdca_pkg::osdca_ph_on;
            next_st.vcount = 6'd0;
          end else begin
            next_st.vcount = st.vcount + 6'd1;
          end
        end
        default: begin
          next_st.phase = osdca_pkg::osdca_ph_on;
          next_st.vcount = 6'd0;
        end
      endcase
    end

    // block nesting depth for the selected layer
    if (block_start & irq_elig & ~(block_end & irq_elig)) begin
      next_st.nest = (st.nest == 4'hf) ? st.nest : st.nest + 4'd1;
    end else if (block_end & irq_elig & ~block_start) begin
      next_st.nest = (st.nest == 4'd0) ? 4'd0 : st.nest - 4'd1;
    end
    next_st.irq = irq_fire;
    if (irq_fire) begin
      next_st.irq_count = st.irq_count + 8'd1;
    end

    // pixel colour, priority: flash-out, font, border, background
    next_st.font_on = fg & ~blink;
    if (blink_cell) begin
      next_st.color = osdca_pkg::CLEAR_PAL;
    end else if (fg & ~blink) begin
      next_st.color = font_pal;
    end else if (border_px) begin
      next_st.color = osdca_pkg::BORDER_PAL;
    end else if (in_char_area & solid_cell & ~solid_sec) begin
      next_st.color = osdca_pkg::SOLID_BG_PAL;
    end else if (in_char_area) begin
      next_st.color = back_pal;
    end else begin
      next_st.color = osdca_pkg::CLEAR_PAL;
    end

    // primary blank: solid space, display area, or border
    if (solid_on & ~solid_sec) begin
      next_st.blank_p = solid_cell;
    end else begin
      next_st.blank_p = in_char_area | border_px;
    end
    if (blink_cell & ~solid_cell) begin
      next_st.blank_p = 1'b0;
    end
    // secondary blank is never gated by flash
    next_st.blank_s = char_second_blank_bit
                      & (in_char_area | (solid_on & solid_sec & solid_cell));

    // scan mode
    if (st.ctrl1[osdca_pkg::C1_BISCAN]) begin
      next_st.vstart = {vpos, 1'b0};
      next_st.vrepeat = {dot_height, 1'b0};
    end else begin
      next_st.vstart = {1'b0, vpos};
      next_st.vrepeat = {1'b0, dot_height};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
      st.ctrl1 <= osdca_pkg::CTRL_RESET;
      st.ctrl2 <= osdca_pkg::CTRL_RESET;
      st.ctrl3 <= osdca_pkg::CTRL_RESET;
      st.phase <= osdca_pkg::osdca_ph_on;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o            = st.rdata;
  assign wb_ack_o            = st.ack;
  assign pix_pal             = st.color;
  assign pix_font            = st.font_on;
  assign blank_out_primary   = st.blank_p;
  assign blank_out_secondary = st.blank_s;
  assign osd_irq             = st.irq;
  assign vstart_line         = st.vstart;
  assign line_repeat         = st.vrepeat;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!nrst);

  flash_on_end_a: assert property (
    vsync_pulse && st.phase == osdca_pkg::osdca_ph_on && st.vcount == 6'd47
    |=> st.phase == osdca_pkg::osdca_ph_off && st.vcount == 6'd0)
    else $error("flash on phase did not end after 48 vsyncs");
  flash_off_end_a: assert property (
    vsync_pulse && st.phase == osdca_pkg::osdca_ph_off && st.vcount == 6'd15
    |=> st.phase == osdca_pkg::osdca_ph_on)
    else $error("flash off phase did not end after 16 vsyncs");
  flash_caption_a: assert property (
    !caption_mode && fg |=> pix_font)
    else $error("font flashed outside caption mode");
  secondary_steady_a: assert property (
    char_second_blank_bit && in_char_area |=> blank_out_secondary)
    else $error("secondary blank dropped");
  underline_line_a: assert property (
    caption_mode && char_underline_bit && in_char_area && !blink
    && font_line == 5'd22 |=> pix_font && pix_pal == $past(font_pal))
    else $error("underline missing on line 23");
  border_color_a: assert property (
    border_px |=> pix_pal == 4'h8 && blank_out_primary)
    else $error("border not drawn in code 8 on primary blank");
  scope_all_a: assert property (
    blink_cell && !solid_cell |=> pix_pal == 4'h0 && !blank_out_primary)
    else $error("whole cell did not flash");
  irq_layer_a: assert property (
    block_end && !irq_sel |=> !osd_irq)
    else $error("interrupt from unselected layer");
  irq_off_block_a: assert property (
    block_end && !block_shown && !block_window_off |=> !osd_irq)
    else $error("interrupt for block switched off");
  biscan_start_a: assert property (
    st.ctrl1[1] |=> vstart_line == {$past(vpos), 1'b0})
    else $error("bi-scan start not doubled");
  bus_ack_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  flash_toggle_c: cover property (st.phase == osdca_pkg::osdca_ph_off ##1
    st.phase == osdca_pkg::osdca_ph_on);
  irq_fire_c: cover property (block_start && irq_elig ##[1:20] osd_irq);
  border_c: cover property (border_px ##1 blank_out_primary);
  solid_c: cover property (solid_cell && solid_sec ##1 blank_out_secondary);

endmodule : osdca_top

/* File: verification/osdca_crt_model.sv */
// frame pulse source standing in for the display timing side
module osdca_crt_model #(
  parameter int VPERIOD = 6
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      vsync_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // one-cycle pulse per frame; the line rests low between frames and while stopped
  always_ff @(posedge core_clk) begin
    if (!nrst || !run) begin
      cnt         <= 0;
      vsync_pulse <= 1'b0;
    end else begin
      cnt         <= (cnt == VPERIOD - 1) ? 0 : cnt + 1;
      vsync_pulse <= (cnt == VPERIOD - 1);
    end
  end
endmodule : osdca_crt_model

/* File: verification/osdca_top_tb.sv */
// self-checking bench for the osd character attribute block
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module osdca_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vs_run, e;
  logic        vsync_pulse, caption_mode, overlay_mode, in_char_area, past_last_char;
  logic        dot_half, char_slant_bit, left_slant_bit, right_slant_bit, char_blink_bit;
  logic        char_underline_bit, char_second_blank_bit, block_start, block_end;
  logic        block_layer2, block_shown, block_window_off, pix_font, osd_irq;
  logic        blank_out_primary, blank_out_secondary;
  logic [2:0]  dot_height;
  logic [3:0]  wb_sel_i, dot_col, font_pal, back_pal, block_index, pix_pal, line_repeat;
  logic [4:0]  font_line;
  logic [7:0]  wb_adr_i;
  logic [8:0]  char_code, left_code, right_code;
  logic [9:0]  vpos;
  logic [10:0] vstart_line;
  logic [15:0] font_row, font_row_up, font_row_dn, left_row, right_row;
  logic [31:0] wb_dat_i, wb_dat_o, rd, d;
  int          n_errors, compares, seed, nvs;

  osdca_top dut (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .vsync_pulse, .caption_mode, .overlay_mode,
    .in_char_area, .past_last_char, .font_line, .dot_col, .dot_half, .font_row,
    .font_row_up, .font_row_dn, .left_row, .right_row, .char_code, .left_code,
    .right_code, .char_slant_bit, .left_slant_bit, .right_slant_bit, .char_blink_bit,
    .char_underline_bit, .char_second_blank_bit, .font_pal, .back_pal, .block_index,
    .block_start, .block_end, .block_layer2, .block_shown, .block_window_off, .vpos,
    .dot_height, .pix_pal, .pix_font, .blank_out_primary, .blank_out_secondary,
    .osd_irq, .vstart_line, .line_repeat);
  osdca_crt_model #(.VPERIOD(6)) crt (.core_clk, .nrst, .run(vs_run), .vsync_pulse);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // request held until ack is sampled high at an edge; data taken and request
  // released at that same edge; only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    `CHK(rd, x)
  endtask : rchk

  // result of the dot driven at the previous edge shows after the next one
  task automatic pchk(input logic f, input logic [3:0] p);
    @(posedge core_clk);
    #1;
    `CHK(pix_font, f)
    `CHK(pix_pal, p)
  endtask : pchk

  // frame source stopped between calls so the count stays exact
  task automatic vs(input int n);
    int k, t;
    k = 0;
    t = 0;
    @(posedge core_clk);
    vs_run <= 1'b1;
    while (k < n && t < 1000) begin
      @(posedge core_clk);
      #1;
      t++;
      if (vsync_pulse === 1'b1) k++;
    end
    if (k < n) n_errors++;
    nvs += k;
    @(posedge core_clk);
    vs_run <= 1'b0;
  endtask : vs

  task automatic fchk;
    wb(1'b0, osdca_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[0], 1'(nvs % 64 >= 48))
  endtask : fchk

  initial begin
    #50000;
    n_errors++;
    summarize();
  end

  initial begin
    seed = 46;
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, vs_run, caption_mode, overlay_mode, in_char_area,
     past_last_char, dot_half, char_slant_bit, left_slant_bit, right_slant_bit,
     char_blink_bit, char_underline_bit, char_second_blank_bit, block_start, block_end,
     block_layer2, block_shown, block_window_off} = '0;
    {wb_adr_i, wb_dat_i, font_line, dot_col, font_row, font_row_up, font_row_dn, left_row,
     right_row, char_code, left_code, right_code, font_pal, back_pal, block_index, vpos,
     dot_height} = '0;
    wb_sel_i = 4'hf;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0);
    // status is read-only and 0x14 is unmapped, both must read back zero
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      wb(1'b1, 8'(4 * i), d);
      rchk(8'(4 * i), i == 2 ? {16'h0, d[15:0]} : (i > 3 ? 32'h0 : {24'h0, d[7:0]}));
    end
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(8'(4 * i), 32'h0);
    in_char_area <= 1'b1;
    back_pal     <= 4'h3;
    font_pal     <= 4'h5;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      caption_mode       <= !i[3];
      overlay_mode       <= i[3];
      char_underline_bit <= i[2];
      font_line          <= 5'(20 + i[1:0]);
      e = i[2] && !i[3] && (5'(20 + i[1:0]) inside {osdca_pkg::UL_LINE_A, osdca_pkg::UL_LINE_B});
      pchk(e, e ? 4'h5 : 4'h3);
    end
    vs(47);
    fchk();
    vs(1);
    fchk();
    font_row              <= 16'hffff;
    font_line             <= 5'd10;
    char_underline_bit    <= 1'b0;
    char_second_blank_bit <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      caption_mode   <= i != 2;
      overlay_mode   <= i == 2;
      char_blink_bit <= i != 1;
      pchk(i != 0, i != 0 ? 4'h5 : 4'h3);
      `CHK(blank_out_secondary, 1'b1)
    end
    wb(1'b1, osdca_pkg::ADR_CTRL1, 32'h1 << osdca_pkg::C1_FLASH_ALL);
    caption_mode   <= 1'b1;
    overlay_mode   <= 1'b0;
    char_blink_bit <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK(pix_pal, osdca_pkg::CLEAR_PAL)
    `CHK(blank_out_primary, 1'b0)
    `CHK(blank_out_secondary, 1'b1)
    vs(15);
    fchk();
    vs(1);
    fchk();
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, osdca_pkg::ADR_CTRL2, {24'h0, i[0], 7'h0});
      block_layer2     <= i[1];
      block_shown      <= i[2];
      block_window_off <= i[3];
      block_start      <= 1'b1;
      @(posedge core_clk);
      block_start <= 1'b0;
      repeat (3) @(posedge core_clk);
      block_end <= 1'b1;
      @(posedge core_clk);
      block_end <= 1'b0;
      #1;
      `CHK(osd_irq, 1'(i[0] == i[1] && (i[2] || i[3])))
      @(posedge core_clk);
      #1;
      `CHK(osd_irq, 1'b0)
    end
    // two eligible blocks overlap: one interrupt, at the later end only
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      block_start <= i < 2;
      block_end   <= i inside {2, 3};
      #1;
      `CHK(osd_irq, 1'(i == 4))
    end
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, osdca_pkg::ADR_CTRL1, {30'h0, i[0], 1'b0});
      vpos       <= 10'($random(seed));
      dot_height <= 3'($random(seed));
      @(posedge core_clk);
      #1;
      `CHK(vstart_line, i[0] ? {vpos, 1'b0} : {1'b0, vpos})
      `CHK(line_repeat, i[0] ? {dot_height, 1'b0} : {1'b0, dot_height})
    end
    wb(1'b1, osdca_pkg::ADR_CTRL1, 32'h10);
    font_row       <= 16'h0;
    char_blink_bit <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, osdca_pkg::ADR_CTRL2, {28'h0, i[3], 3'h0});
      char_code             <= i[0] ? osdca_pkg::NO_SOLID_CODE : 9'h041;
      left_code             <= i[1] ? osdca_pkg::NO_SOLID_CODE : 9'h0a2;
      right_code            <= i[2] ? osdca_pkg::NO_SOLID_CODE : 9'h1c3;
      char_second_blank_bit <= i[1];
      e = i[2:0] != 3'h7 && !i[3];
      pchk(1'b0, e ? osdca_pkg::SOLID_BG_PAL : 4'h3);
      if (!i[3]) `CHK(blank_out_primary, e)
      `CHK(blank_out_secondary, i[1])
    end
    wb(1'b1, osdca_pkg::ADR_CTRL1, 32'h0);
    block_index <= 4'h6;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, osdca_pkg::ADR_BORDER, {25'h0, i[0], 6'h0});
      d = 1 + $unsigned($random(seed)) % 15;
      dot_col      <= 4'(d);
      font_row     <= 16'((i[2] ? 3 : 1) << (d - 1));
      overlay_mode <= i[1];
      caption_mode <= !i[1];
      e = i[0] && i[1] && !i[2];
      pchk(i[2], i[2] ? 4'h5 : (e ? osdca_pkg::BORDER_PAL : 4'h3));
      if (e) `CHK(blank_out_primary, 1'b1)
    end
    // italic: font dot 0 of line 0 lands d half dots right; the core clock here
    // stands for a display clock that software keeps in the italic range
    @(posedge core_clk);
    caption_mode <= 1'b1;
    overlay_mode <= 1'b0;
    font_row     <= 16'h0001;
    font_line    <= 5'd0;
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, osdca_pkg::ADR_CTRL3, {31'h0, i[2]});
      d = i[2] ? 25 * 10 / 26 - i[1] : 2 * (25 * 5 / 26) - 2 * i[1];
      char_slant_bit <= !i[0];
      left_slant_bit <= i[0];
      dot_col        <= 4'(d >> 1);
      dot_half       <= d[0];
      pchk(!i[1], i[1] ? 4'h3 : 4'h5);
    end
    // spill right of the 32nd cell shows only while solid space is on
    wb(1'b1, osdca_pkg::ADR_CTRL3, 32'h0);
    in_char_area   <= 1'b0;
    past_last_char <= 1'b1;
    font_row       <= 16'h0000;
    left_row       <= 16'h8000;
    dot_col        <= 4'd3;
    dot_half       <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, osdca_pkg::ADR_CTRL1, {27'h0, !i[0], 4'h0});
      pchk(!i[0], i[0] ? osdca_pkg::CLEAR_PAL : 4'h5);
    end
    // second border dot only at ratio 2 with 1.5 dot size, first half only
    @(posedge core_clk);
    in_char_area   <= 1'b1;
    past_last_char <= 1'b0;
    left_row       <= 16'h0000;
    font_row       <= 16'h0001;
    dot_col        <= 4'd2;
    caption_mode   <= 1'b0;
    overlay_mode   <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, osdca_pkg::ADR_CTRL3, {30'h0, i[1], i[1]});
      dot_half <= i[0] & i[1];
      e = i[1] && !i[0];
      pchk(1'b0, e ? osdca_pkg::BORDER_PAL : 4'h3);
    end
    summarize();
  end
endmodule : osdca_top_tb
